/* File: tb/aic_analog_model.sv */
// Far side model: comparator on a fixed analog level and the dedicated oscillator.
`timescale 1ns/1ns
module aic_analog_model #(
    parameter logic [11:0] LEVEL = 12'hA5C,
    parameter int HALF = 3
) (
    // Clock.
    input wire logic sys_clk,
    // Converter side.
    input wire logic [11:0] trial_code,
    input wire logic osc_run,
    output logic comparator_high,
    output logic dedicated_conversion_oscillator
);
    int cnt = 0;

    assign comparator_high = (LEVEL >= trial_code);

    // The oscillator stands low while not running.
    initial dedicated_conversion_oscillator = 1'b0;
    always @(posedge sys_clk)
    begin
        cnt <= (cnt == HALF - 1) ? 0 : cnt + 1;
        if (!osc_run)
            dedicated_conversion_oscillator <= 1'b0;
        else if (cnt == HALF - 1)
            dedicated_conversion_oscillator <= !dedicated_conversion_oscillator;
    end
endmodule

/* File: tb/aic_converter_config_checker.sv */
// Concurrent checks on the converter configuration outputs.
`timescale 1ns/1ns
module aic_converter_config_checker (
    // Clock and reset.
    input wire logic sys_clk,
    input wire logic reset_n,
    // Pin function.
    input wire logic [7:0] pin_analog_enable,
    input wire logic [7:0] pin_digital_input_enable,
    // Front end selection.
    input wire logic [4:0] positive_channel_select,
    input wire logic [3:0] negative_channel_select,
    input wire logic single_ended,
    input wire logic [1:0] positive_reference_select,
    // Converter core.
    input wire logic sample_enable,
    input wire logic [11:0] trial_code,
    input wire logic conversion_busy
);
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!reset_n);

    sequence s_start;
        $rose(conversion_busy);
    endsequence

    sequence s_first_period_end;
        $fell(sample_enable) && conversion_busy;
    endsequence

    a_buffer_inverse: assert property (pin_digital_input_enable == ~pin_analog_enable)
        else $error("digital buffer enable is not the inverse of analog select");
    a_bit_six_zero: assert property (!pin_analog_enable[6])
        else $error("unimplemented analog select bit is set");
    a_channel_range: assert property (positive_channel_select <= 5'h0D)
        else $error("positive channel outside the fourteen sources");
    a_single_ended_code: assert property (single_ended == (negative_channel_select == 4'hF))
        else $error("single ended flag disagrees with negative channel");
    a_pref_legal: assert property (positive_reference_select != 2'h3)
        else $error("positive reference holds an undefined code");
    a_start_state: assert property (s_start |-> sample_enable && trial_code == 12'h000)
        else $error("conversion did not start sampling with a clear trial word");
    a_first_trial: assert property (s_first_period_end |-> trial_code == 12'h800)
        else $error("first bit period did not set the top trial bit");
    a_busy_span: assert property (s_start |-> conversion_busy [*8])
        else $error("conversion ended far too early");
endmodule

bind aic_converter_config aic_converter_config_checker i_chk (.*);

/* File: tb/aic_converter_config_tb.sv */
// Self-checking bench for the converter configuration block.
`timescale 1ns/1ns
module aic_converter_config_tb;
    logic sys_clk = 1'b0;
    logic reset_n = 1'b0;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
    logic [3:0] s_axi_wstrb = 4'h1;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, osc_run = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp, positive_reference_select;
    logic [7:0] pin_analog_enable, pin_digital_input_enable;
    logic [4:0] positive_channel_select;
    logic [3:0] negative_channel_select;
    logic single_ended, negative_reference_select, dedicated_conversion_oscillator;
    logic comparator_high, sample_enable, conversion_busy;
    logic [11:0] trial_code;
    int n_mismatch = 0, check_count = 0, cycles = 0, len, lo, hi;

    aic_converter_config i_dut (.*);
    aic_analog_model i_model (.*);

    always #2 sys_clk = ~sys_clk;

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        @(posedge sys_clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        fork
            begin
                do @(posedge sys_clk); while (!s_axi_awready);
                s_axi_awvalid <= 1'b0;
            end
            begin
                do @(posedge sys_clk); while (!s_axi_wready);
                s_axi_wvalid <= 1'b0;
            end
        join
        do @(posedge sys_clk); while (!s_axi_bvalid);
        s_axi_bready <= 1'b0;
        chk("bresp", 32'(s_axi_bresp), 32'(er));
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
        @(posedge sys_clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do @(posedge sys_clk); while (!s_axi_arready);
        s_axi_arvalid <= 1'b0;
        do @(posedge sys_clk); while (!s_axi_rvalid);
        s_axi_rready <= 1'b0;
        chk("rdata", s_axi_rdata, exp);
        chk("rresp", 32'(s_axi_rresp), 32'(er));
    endtask

    task results;
        if (n_mismatch == 0 && check_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    always @(posedge sys_clk)
    begin
        cycles++;
        if (cycles == 30000)
        begin
            n_mismatch++;
            results();
        end
    end

    initial
    begin
        repeat (16) @(posedge sys_clk);
        reset_n <= 1'b1;
        chk("digital_buf", 32'(pin_digital_input_enable), 32'h40);
        rd(8'h00, 32'hBF, 2'h0);
        wr(8'h00, 32'hFF, 2'h0);
        rd(8'h00, 32'hBF, 2'h0);
        wr(8'h00, 32'h15, 2'h0);
        chk("digital_buf", 32'(pin_digital_input_enable), 32'hEA);
        chk("analog_sel", 32'(pin_analog_enable), 32'h15);
        for (int c = 0; c < 15; c++)
        begin
            wr(8'h04, 32'(c) << 2, 2'h0);
            chk("pos_chan", 32'(positive_channel_select), (c < 14) ? c : 13);
        end
        for (int n = 0; n < 16; n++)
        begin
            wr(8'h0C, n, 2'h0);
            chk("neg_chan", 32'(negative_channel_select), n);
            chk("single", 32'(single_ended), 32'(n == 15));
        end
        for (int r = 0; r < 4; r++)
        begin
            wr(8'h08, 32'(r) | (32'(r & 1) << 2), 2'h0);
            chk("pos_ref", 32'(positive_reference_select), (r < 3) ? r : 2);
            chk("neg_ref", 32'(negative_reference_select), r & 1);
        end
        wr(8'h20, 32'h0, 2'h2);
        rd(8'h14, 32'h0, 2'h2);
        wr(8'h10, 32'hFFF, 2'h0);
        // Channel 0 is selected ahead of the first start so acquisition has time to settle.
        wr(8'h04, 32'h0, 2'h0);
        for (int n = 0; n < 7; n++)
        begin
            osc_run <= (n == 6);
            wr(8'h08, 32'(n) << 4, 2'h0);
            repeat (4) @(posedge sys_clk);
            wr(8'h04, 32'h3, 2'h0);
            lo = (n < 6) ? 15 * (2 << n) - 1 : 84;
            hi = (n < 6) ? 15 * (2 << n) + 2 : 99;
            len = 0;
            while (conversion_busy !== 1'b1 && len < 4)
            begin
                @(posedge sys_clk);
                len++;
            end
            len = 0;
            while (conversion_busy === 1'b1)
            begin
                @(posedge sys_clk);
                len++;
            end
            chk("busy_len", 32'(len >= lo && len <= hi), 32'h1);
            rd(8'h10, 32'h00010A5C, 2'h0);
        end
        // Clearing enable mid-conversion aborts it without setting done.
        wr(8'h04, 32'h3, 2'h0);
        wr(8'h04, 32'h0, 2'h0);
        @(posedge sys_clk);
        chk("abort_busy", 32'(conversion_busy), 32'h0);
        rd(8'h10, 32'h00000A5C, 2'h0);
        results();
    end
endmodule

/* File: verilog/aic_clock_divider.sv */
// Divider that pulses once per 2, 4, 8, 16, 32 or 64 system clocks.
`timescale 1ns/1ns
module aic_clock_divider #(
    parameter int COUNT_BITS = 6
) (
    // Clock and reset.
    input wire logic sys_clk,
    input wire logic reset_n,
    // Control.
    input wire logic restart,
    input wire logic [2:0] divide_log2_minus1,
    // Output.
    output logic tick
);
    typedef struct packed {
        logic [COUNT_BITS-1:0] count;
        logic tick;
    } aic_div_state_t;

    aic_div_state_t cur_ff;
    aic_div_state_t nxt_state;
    logic [COUNT_BITS-1:0] last_count;

    always_comb
    begin
        last_count = COUNT_BITS'((2 << divide_log2_minus1) - 1);
        nxt_state = cur_ff;
        nxt_state.tick = 1'b0;
        if (restart)
        begin
            nxt_state.count = '0;
        end
        else if (cur_ff.count >= last_count)
        begin
            nxt_state.count = '0;
            nxt_state.tick = 1'b1;
        end
        else
        begin
            nxt_state.count = cur_ff.count + 1'b1;
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
            cur_ff <= '0;
        else
            cur_ff <= nxt_state;
    end

    assign tick = cur_ff.tick;
endmodule

/* File: verilog/aic_converter_config.sv */
// Converter input, reference and conversion clock configuration with its SAR sequencer.
// Overview of operation
// - Analog select bit disables pin digital buffer.
// - Port bit six reads zero, ignores writes.
// - Fourteen positive sources: pins, temperature, DAC, reference.
// - Five-bit field picks positive converter input.
// - Four-bit field picks any negative input.
// - Negative field all ones means single-ended.
// - Positive reference: external pin, supply, buffer one.
// - Negative reference: external pin or ground.
// - Seven conversion clocks: divided system or oscillator.
// - Twelve-bit conversion takes fifteen bit periods.
// - Divided clocks follow any system clock change.
//
// The implementer's own choices: the register addresses and the AXI4-Lite interface to the registers.
`timescale 1ns/1ns
module aic_converter_config #(
    parameter int ADDR_BITS = 8
) (
    // Clock and reset.
    input wire logic sys_clk,
    input wire logic reset_n,
    // AXI4-Lite write address and data.
    input wire logic [ADDR_BITS-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // AXI4-Lite write response.
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read.
    input wire logic [ADDR_BITS-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Port A pin function.
    output logic [7:0] pin_analog_enable,
    output logic [7:0] pin_digital_input_enable,
    // Analog front end selection.
    output logic [4:0] positive_channel_select,
    output logic [3:0] negative_channel_select,
    output logic single_ended,
    output logic [1:0] positive_reference_select,
    output logic negative_reference_select,
    // Converter core.
    input wire logic dedicated_conversion_oscillator,
    input wire logic comparator_high,
    output logic sample_enable,
    output logic [11:0] trial_code,
    output logic conversion_busy
);
    typedef struct packed {
        aic_pkg::aic_config_t cfg;
        logic [7:0] digital_enable;
        logic single_ended;
        logic aw_held;
        logic [ADDR_BITS-1:0] aw_addr;
        logic w_held;
        logic [7:0] w_byte;
        logic w_lane0;
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic busy;
        logic sampling;
        logic [3:0] period_index;
        logic [11:0] code;
        logic [11:0] result;
        logic done;
    } aic_state_t;

    aic_state_t cur_ff;
    aic_state_t nxt_state;
    logic div_tick;
    logic osc_tick;
    logic period_tick;
    logic start_pulse;
    logic do_write;
    logic do_read;
    logic [3:0] bit_pos;

    // Only a fresh start realigns the divider, so the first period is full length on a divided clock.
    aic_clock_divider #(
        .COUNT_BITS(6)
    ) u_divider (
        .sys_clk(sys_clk),
        .reset_n(reset_n),
        .restart(start_pulse),
        .divide_log2_minus1(cur_ff.cfg.clock_select),
        .tick(div_tick)
    );

    aic_osc_edge u_osc_edge (
        .sys_clk(sys_clk),
        .reset_n(reset_n),
        .osc_level(dedicated_conversion_oscillator),
        .tick(osc_tick)
    );

    // Divided ticks are counted on sys_clk, so they track its rate.
    assign period_tick = (cur_ff.cfg.clock_select == aic_pkg::CLKSEL_DEDICATED_OSC) ?
        osc_tick : div_tick;

    always_comb
    begin
        nxt_state = cur_ff;
        start_pulse = 1'b0;
        bit_pos = 4'h0;

        // Address and data are taken in either order and held until both are present.
        if (cur_ff.awready && s_axi_awvalid)
        begin
            nxt_state.aw_held = 1'b1;
            nxt_state.aw_addr = s_axi_awaddr;
        end
        if (cur_ff.wready && s_axi_wvalid)
        begin
            nxt_state.w_held = 1'b1;
            nxt_state.w_byte = s_axi_wdata[7:0];
            nxt_state.w_lane0 = s_axi_wstrb[0];
        end
        if (cur_ff.bvalid && s_axi_bready)
        begin
            nxt_state.bvalid = 1'b0;
        end

        do_write = cur_ff.aw_held && cur_ff.w_held && !cur_ff.bvalid;
        if (do_write)
        begin
            nxt_state.aw_held = 1'b0;
            nxt_state.w_held = 1'b0;
            nxt_state.bvalid = 1'b1;
            nxt_state.bresp = aic_pkg::RESP_OKAY;
            case (cur_ff.aw_addr)
                aic_pkg::OFS_PORT_A_ANALOG_SELECT:
                begin
                    if (cur_ff.w_lane0)
                    begin
                        nxt_state.cfg.analog_select =
                            cur_ff.w_byte & aic_pkg::IMPL_MASK_PORT_A;
                    end
                end
                aic_pkg::OFS_CONVERTER_CONTROL_FIRST:
                begin
                    if (cur_ff.w_lane0)
                    begin
                        nxt_state.cfg.enable = cur_ff.w_byte[aic_pkg::POS_ENABLE];
                        // Codes beyond the fourteen sources leave the field as it was.
                        if (cur_ff.w_byte[aic_pkg::POS_POSITIVE_CHANNEL +: 5] <=
                            aic_pkg::CHAN_LAST)
                        begin
                            nxt_state.cfg.positive_channel =
                                cur_ff.w_byte[aic_pkg::POS_POSITIVE_CHANNEL +: 5];
                        end
                        if (cur_ff.w_byte[aic_pkg::POS_START_BUSY] &&
                            cur_ff.w_byte[aic_pkg::POS_ENABLE] && !cur_ff.busy)
                        begin
                            start_pulse = 1'b1;
                        end
                    end
                end
                aic_pkg::OFS_CONVERTER_CONTROL_SECOND:
                begin
                    if (cur_ff.w_lane0)
                    begin
                        if (cur_ff.w_byte[aic_pkg::POS_POSITIVE_REFERENCE +: 2] !=
                            2'h3)
                        begin
                            nxt_state.cfg.positive_reference =
                                cur_ff.w_byte[aic_pkg::POS_POSITIVE_REFERENCE +: 2];
                        end
                        nxt_state.cfg.negative_reference =
                            cur_ff.w_byte[aic_pkg::POS_NEGATIVE_REFERENCE];
                        if (cur_ff.w_byte[aic_pkg::POS_CLOCK_SELECT +: 3] != 3'h7)
                        begin
                            nxt_state.cfg.clock_select =
                                cur_ff.w_byte[aic_pkg::POS_CLOCK_SELECT +: 3];
                        end
                    end
                end
                aic_pkg::OFS_CONVERTER_CONTROL_THIRD:
                begin
                    if (cur_ff.w_lane0)
                    begin
                        nxt_state.cfg.negative_channel =
                            cur_ff.w_byte[aic_pkg::POS_NEGATIVE_CHANNEL +: 4];
                    end
                end
                aic_pkg::OFS_CONVERSION_RESULT:
                begin
                    nxt_state.bresp = aic_pkg::RESP_OKAY;
                end
                default:
                begin
                    nxt_state.bresp = aic_pkg::RESP_SLVERR;
                end
            endcase
        end

        // Read channel: one read under way, answered the cycle after the address is taken.
        if (cur_ff.rvalid && s_axi_rready)
        begin
            nxt_state.rvalid = 1'b0;
        end
        do_read = cur_ff.arready && s_axi_arvalid;
        if (do_read)
        begin
            nxt_state.rvalid = 1'b1;
            nxt_state.rresp = aic_pkg::RESP_OKAY;
            nxt_state.rdata = 32'h0000_0000;
            case (s_axi_araddr)
                aic_pkg::OFS_PORT_A_ANALOG_SELECT:
                begin
                    nxt_state.rdata[7:0] = cur_ff.cfg.analog_select;
                end
                aic_pkg::OFS_CONVERTER_CONTROL_FIRST:
                begin
                    nxt_state.rdata[aic_pkg::POS_ENABLE] = cur_ff.cfg.enable;
                    nxt_state.rdata[aic_pkg::POS_START_BUSY] = cur_ff.busy;
                    nxt_state.rdata[aic_pkg::POS_POSITIVE_CHANNEL +: 5] =
                        cur_ff.cfg.positive_channel;
                end
                aic_pkg::OFS_CONVERTER_CONTROL_SECOND:
                begin
                    nxt_state.rdata[aic_pkg::POS_POSITIVE_REFERENCE +: 2] =
                        cur_ff.cfg.positive_reference;
                    nxt_state.rdata[aic_pkg::POS_NEGATIVE_REFERENCE] =
                        cur_ff.cfg.negative_reference;
                    nxt_state.rdata[aic_pkg::POS_CLOCK_SELECT +: 3] = cur_ff.cfg.clock_select;
                end
                aic_pkg::OFS_CONVERTER_CONTROL_THIRD:
                begin
                    nxt_state.rdata[aic_pkg::POS_NEGATIVE_CHANNEL +: 4] =
                        cur_ff.cfg.negative_channel;
                end
                aic_pkg::OFS_CONVERSION_RESULT:
                begin
                    nxt_state.rdata[aic_pkg::RESULT_BITS-1:0] = cur_ff.result;
                    nxt_state.rdata[aic_pkg::POS_RESULT_DONE] = cur_ff.done;
                    // Reading the result clears done unless a conversion ends now.
                    nxt_state.done = 1'b0;
                end
                default:
                begin
                    nxt_state.rresp = aic_pkg::RESP_SLVERR;
                end
            endcase
        end

        // Sequencer: period 0 ends sampling, 1 to 12 resolve bits, 14 stores the result.
        if (start_pulse)
        begin
            nxt_state.busy = 1'b1;
            nxt_state.sampling = 1'b1;
            nxt_state.period_index = 4'h0;
            nxt_state.code = 12'h000;
        end
        else if (cur_ff.busy && !cur_ff.cfg.enable)
        begin
            nxt_state.busy = 1'b0;
            nxt_state.sampling = 1'b0;
        end
        else if (cur_ff.busy && period_tick)
        begin
            nxt_state.period_index = cur_ff.period_index + 4'h1;
            if (cur_ff.period_index == 4'h0)
            begin
                nxt_state.sampling = 1'b0;
                nxt_state.code = 12'h800;
            end
            else if (cur_ff.period_index <= 4'hC)
            begin
                bit_pos = 4'hC - cur_ff.period_index;
                if (!comparator_high)
                begin
                    nxt_state.code[bit_pos] = 1'b0;
                end
                if (bit_pos != 4'h0)
                begin
                    nxt_state.code[bit_pos - 4'h1] = 1'b1;
                end
            end
            else if (cur_ff.period_index == aic_pkg::CONVERSION_PERIODS - 4'h1)
            begin
                nxt_state.busy = 1'b0;
                nxt_state.result = cur_ff.code;
                nxt_state.done = 1'b1;
            end
        end

        // Pin buffers follow the analog select bits; bit six has no pin control.
        nxt_state.digital_enable = ~nxt_state.cfg.analog_select;
        nxt_state.single_ended =
            (nxt_state.cfg.negative_channel == aic_pkg::NEG_SINGLE_ENDED);

        // Each ready is offered only while its own channel holds nothing and no response is pending on its side.
        nxt_state.awready = !nxt_state.aw_held && !nxt_state.bvalid;
        nxt_state.wready = !nxt_state.w_held && !nxt_state.bvalid;
        nxt_state.arready = !nxt_state.rvalid;
    end

    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            cur_ff <= '0;
            cur_ff.cfg.analog_select <= aic_pkg::RST_PORT_A_ANALOG_SELECT;
            cur_ff.cfg.positive_channel <= aic_pkg::RST_POSITIVE_CHANNEL;
            cur_ff.cfg.negative_channel <= aic_pkg::RST_NEGATIVE_CHANNEL;
            cur_ff.cfg.positive_reference <= aic_pkg::RST_POSITIVE_REFERENCE;
            cur_ff.cfg.negative_reference <= aic_pkg::RST_NEGATIVE_REFERENCE;
            cur_ff.cfg.clock_select <= aic_pkg::RST_CLOCK_SELECT;
            cur_ff.digital_enable <= ~aic_pkg::RST_PORT_A_ANALOG_SELECT;
            cur_ff.single_ended <= 1'b1;
        end
        else
        begin
            cur_ff <= nxt_state;
        end
    end

    assign s_axi_awready = cur_ff.awready;
    assign s_axi_wready = cur_ff.wready;
    assign s_axi_bresp = cur_ff.bresp;
    assign s_axi_bvalid = cur_ff.bvalid;
    assign s_axi_arready = cur_ff.arready;
    assign s_axi_rdata = cur_ff.rdata;
    assign s_axi_rresp = cur_ff.rresp;
    assign s_axi_rvalid = cur_ff.rvalid;
    assign pin_analog_enable = cur_ff.cfg.analog_select;
    assign pin_digital_input_enable = cur_ff.digital_enable;
    assign positive_channel_select = cur_ff.cfg.positive_channel;
    assign negative_channel_select = cur_ff.cfg.negative_channel;
    assign single_ended = cur_ff.single_ended;
    assign positive_reference_select = cur_ff.cfg.positive_reference;
    assign negative_reference_select = cur_ff.cfg.negative_reference;
    assign sample_enable = cur_ff.sampling;
    assign trial_code = cur_ff.code;
    assign conversion_busy = cur_ff.busy;
endmodule

/* File: verilog/aic_osc_edge.sv */
// Rising-edge pulse from the dedicated conversion oscillator input.
`timescale 1ns/1ns
module aic_osc_edge (
    // Clock and reset.
    input wire logic sys_clk,
    input wire logic reset_n,
    // Oscillator level and pulse.
    input wire logic osc_level,
    output logic tick
);
    typedef struct packed {
        logic last;
        logic tick;
    } aic_edge_state_t;

    aic_edge_state_t cur_ff;
    aic_edge_state_t nxt_state;

    always_comb
    begin
        nxt_state.last = osc_level;
        nxt_state.tick = osc_level & ~cur_ff.last;
    end

    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
            cur_ff <= '0;
        else
            cur_ff <= nxt_state;
    end

    assign tick = cur_ff.tick;
endmodule

/* File: verilog/aic_pkg.sv */
// Package with register map, field layout, encodings and reset values of the converter config.
package aic_pkg;

    // Register byte offsets on the AXI4-Lite slave.
    localparam logic [7:0] OFS_PORT_A_ANALOG_SELECT = 8'h00;
    localparam logic [7:0] OFS_CONVERTER_CONTROL_FIRST = 8'h04;
    localparam logic [7:0] OFS_CONVERTER_CONTROL_SECOND = 8'h08;
    localparam logic [7:0] OFS_CONVERTER_CONTROL_THIRD = 8'h0C;
    localparam logic [7:0] OFS_CONVERSION_RESULT = 8'h10;

    // Values after reset.
    localparam logic [7:0] RST_PORT_A_ANALOG_SELECT = 8'hBF;
    localparam logic [7:0] IMPL_MASK_PORT_A = 8'hBF;
    localparam logic [4:0] RST_POSITIVE_CHANNEL = 5'h00;
    localparam logic [3:0] RST_NEGATIVE_CHANNEL = 4'hF;
    localparam logic [1:0] RST_POSITIVE_REFERENCE = 2'h0;
    localparam logic RST_NEGATIVE_REFERENCE = 1'b0;
    localparam logic [2:0] RST_CLOCK_SELECT = 3'h0;

    // Field positions in the control registers.
    localparam int POS_ENABLE = 0;
    localparam int POS_START_BUSY = 1;
    localparam int POS_POSITIVE_CHANNEL = 2;
    localparam int POS_POSITIVE_REFERENCE = 0;
    localparam int POS_NEGATIVE_REFERENCE = 2;
    localparam int POS_CLOCK_SELECT = 4;
    localparam int POS_NEGATIVE_CHANNEL = 0;
    localparam int POS_RESULT_DONE = 16;

    // Positive channel codes: 0..4 pins 0..4, 5..10 pins 8..13, then internal sources.
    localparam logic [4:0] CHAN_TEMPERATURE = 5'h0B;
    localparam logic [4:0] CHAN_DAC_OUTPUT = 5'h0C;
    localparam logic [4:0] CHAN_FIXED_REFERENCE = 5'h0D;
    localparam logic [4:0] CHAN_LAST = 5'h0D;
    localparam logic [3:0] NEG_SINGLE_ENDED = 4'hF;

    // Positive reference codes; code 3 is not accepted.
    localparam logic [1:0] PREF_SUPPLY = 2'h0;
    localparam logic [1:0] PREF_EXTERNAL_PIN = 2'h1;
    localparam logic [1:0] PREF_FIXED_BUFFER1 = 2'h2;
    // Negative reference codes.
    localparam logic NREF_GROUND = 1'b0;
    localparam logic NREF_EXTERNAL_PIN = 1'b1;

    // Clock select codes 0..5 divide the system clock by 2 to 64; code 7 is not accepted.
    localparam logic [2:0] CLKSEL_DEDICATED_OSC = 3'h6;

    // Conversion length in bit periods and result width.
    localparam logic [3:0] CONVERSION_PERIODS = 4'hF;
    localparam int RESULT_BITS = 12;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef struct packed {
        logic [7:0] analog_select;
        logic [4:0] positive_channel;
        logic [3:0] negative_channel;
        logic [1:0] positive_reference;
        logic negative_reference;
        logic [2:0] clock_select;
        logic enable;
    } aic_config_t;

endpackage
